// file: acc_core.sv
`timescale 1ns/1ps
`default_nettype none
module acc_core #(
  parameter int OSR_LOG2 = acc_pkg::OSR_LOG2_DEF
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_b,
  // modulator link, both from outside this clock domain
  input  wire logic          modClk,
  input  wire logic          modBit,
  // configuration write port and readback
  input  wire logic          cfgWr,
  input  wire logic [15:0]   cfgWrData,
  output logic [15:0]        cfgRdData,
  // front end control
  output logic               powerUp,
  output logic [2:0]         gainSelectField,
  output acc_pkg::acc_fs_t   fsRange,
  output logic               tempMode,
  // latest result
  output acc_pkg::acc_result_t resultReg,
  // result stream to the serial side
  output logic               resValid,
  input  wire logic          resReady,
  output acc_pkg::acc_result_t resData
);
  import acc_pkg::*;

  // ==========================================================
  // derived constants
  localparam int SHR = (OSR_LOG2 >= RES_BITS) ? OSR_LOG2 - RES_BITS : 0;
  localparam int SHL = (OSR_LOG2 < RES_BITS) ? RES_BITS - OSR_LOG2 : 0;
  localparam logic [33:0] HALF = 34'(1) << (OSR_LOG2 - 1);
  localparam logic signed [33:0] MAX_POS = 34'sd32767;
  localparam logic signed [33:0] MAX_NEG = -34'sd32768;

  // ==========================================================
  // link synchronisers
  logic clkMeta;
  logic clkSync;
  logic clkLast;
  logic bitMeta;
  logic bitSync;
  logic sampleEdge;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clkMeta <= 1'b0;
      clkSync <= 1'b0;
      clkLast <= 1'b0;
      bitMeta <= 1'b0;
      bitSync <= 1'b0;
    end else begin
      clkMeta <= modClk;
      clkSync <= clkMeta;
      clkLast <= clkSync;
      bitMeta <= modBit;
      bitSync <= bitMeta;
    end
  end

  // both paths carry equal delay, so the bit lines up with its edge
  assign sampleEdge = clkSync & ~clkLast;

  // ==========================================================
  // configuration word
  logic [15:0] cfgReg;
  logic        ssWrite;
  acc_state_t  state;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfgReg <= CFG_RESET;
    end else if (cfgWr) begin
      cfgReg <= cfgWrData;
      cfgReg[SS_BIT] <= 1'b0;
    end
  end

  assign ssWrite = cfgWr & cfgWrData[SS_BIT];
  assign cfgRdData = cfgReg;
  assign gainSelectField = cfgReg[GAIN_HI:GAIN_LO];
  assign tempMode = cfgReg[TS_BIT];
  assign powerUp = (state != ACC_PDOWN);

  // codes above five all select the narrowest range
  always_comb begin
    case (gainSelectField)
      3'b000:  fsRange = ACC_FS_6V144;
      3'b001:  fsRange = ACC_FS_4V096;
      3'b010:  fsRange = ACC_FS_2V048;
      3'b011:  fsRange = ACC_FS_1V024;
      3'b100:  fsRange = ACC_FS_0V512;
      default: fsRange = ACC_FS_0V256;
    endcase
  end

  // ==========================================================
  // sinc1 decimator: count ones over 2**OSR_LOG2 samples
  logic [OSR_LOG2-1:0] sampleCnt;
  logic [OSR_LOG2:0]   onesCnt;
  logic [OSR_LOG2:0]   onesTotal;
  logic                lastSample;

  assign lastSample = sampleEdge & (&sampleCnt) & (state == ACC_CONV);
  assign onesTotal = onesCnt + {{OSR_LOG2{1'b0}}, bitSync};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sampleCnt <= '0;
      onesCnt   <= '0;
    end else if (state != ACC_CONV) begin
      sampleCnt <= '0;
      onesCnt   <= '0;
    end else if (sampleEdge) begin
      sampleCnt <= sampleCnt + 1'b1;
      onesCnt   <= lastSample ? '0 : onesTotal;
    end
  end

  // ==========================================================
  // scaling, clipping and temperature format
  logic signed [33:0] centred;
  logic signed [33:0] scaled;
  logic [15:0]        clipped;
  acc_result_t        next_conv;

  always_comb begin
    centred = $signed(34'(onesTotal) - HALF);
    scaled  = (centred >>> SHR) <<< SHL;
    if (scaled > MAX_POS) begin
      clipped = POS_FS_CODE;
    end else if (scaled < MAX_NEG) begin
      clipped = NEG_FS_CODE;
    end else begin
      clipped = scaled[15:0];
    end
    next_conv.isTemp = tempMode;
    if (tempMode) begin
      next_conv.code = {clipped[15:2], 2'b00};
    end else begin
      next_conv.code = clipped;
    end
  end

  // ==========================================================
  // conversion sequencing
  acc_result_t convResult;
  logic        bufInReady;
  logic        modeSingle;
  logic        doneAny;

  assign modeSingle = cfgReg[MODE_BIT];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ACC_PDOWN;
    end else begin
      case (state)
        ACC_PDOWN: begin
          if (ssWrite) begin
            state <= ACC_CONV;
          end else if (!modeSingle) begin
            state <= ACC_CONV;
          end
        end
        ACC_CONV: begin
          // a start request here is simply not looked at
          if (lastSample) begin
            state <= ACC_DONE;
          end
        end
        ACC_DONE: begin
          if (bufInReady && modeSingle) begin
            state <= ACC_PDOWN;
          end else if (bufInReady) begin
            state <= ACC_CONV;
          end
        end
        default: state <= ACC_PDOWN;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      convResult <= '0;
    end else if (lastSample) begin
      convResult <= next_conv;
    end
  end

  // a stalled reader holds the block in done, so no word is lost
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      resultReg <= '{code: RESULT_RESET, isTemp: 1'b0};
      doneAny   <= 1'b0;
    end else if (state == ACC_DONE && bufInReady) begin
      resultReg <= convResult;
      doneAny   <= 1'b1;
    end
  end

  // ==========================================================
  // two-entry result buffer
  acc_result_t bufMem [BUF_DEPTH];
  logic        wrPtr;
  logic        rdPtr;
  logic [1:0]  bufCnt;
  logic        bufPush;
  logic        bufPop;

  assign bufInReady = (bufCnt != 2'(BUF_DEPTH));
  assign bufPush = (state == ACC_DONE) & bufInReady;
  assign resValid = (bufCnt != 2'd0);
  assign bufPop = resValid & resReady;
  assign resData = bufMem[rdPtr];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bufMem[0] <= '0;
      bufMem[1] <= '0;
    end else if (bufPush) begin
      bufMem[wrPtr] <= convResult;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr  <= 1'b0;
      rdPtr  <= 1'b0;
      bufCnt <= 2'd0;
    end else begin
      if (bufPush) begin
        wrPtr <= ~wrPtr;
      end
      if (bufPop) begin
        rdPtr <= ~rdPtr;
      end
      bufCnt <= bufCnt + 2'(bufPush) - 2'(bufPop);
    end
  end

  // ==========================================================
  // checks
  logic firstCyc;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      firstCyc <= 1'b1;
    end else begin
      firstCyc <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  reset_defaults_a: assert property (
    firstCyc |-> cfgReg == CFG_RESET && state == ACC_PDOWN)
    else $error("configuration or state not at reset value");

  gain_follow_a: assert property (
    cfgWr |=> gainSelectField == $past(cfgWrData[GAIN_HI:GAIN_LO]))
    else $error("gain select did not follow the write");

  range_map_a: assert property (
    (gainSelectField == 3'b000 |-> fsRange == ACC_FS_6V144) and
    (gainSelectField >= 3'b101 |-> fsRange == ACC_FS_0V256))
    else $error("wrong full scale range for gain code");

  clip_pos_a: assert property (
    lastSample && scaled > MAX_POS && !tempMode
      |=> convResult.code == POS_FS_CODE)
    else $error("over range did not clip to 7fff");

  clip_neg_a: assert property (
    lastSample && scaled <= MAX_NEG && !tempMode
      |=> convResult.code == NEG_FS_CODE)
    else $error("under range did not clip to 8000");

  zero_code_a: assert property (
    lastSample && onesTotal == HALF[OSR_LOG2:0] && !tempMode
      |=> convResult.code == 16'h0000)
    else $error("mid scale input did not give zero");

  temp_format_a: assert property (
    lastSample && tempMode |=> convResult.isTemp &&
      convResult.code == {$past(clipped[15:2]), 2'b00})
    else $error("temperature result not left aligned");

  idle_pdown_a: assert property (
    state == ACC_PDOWN |-> !powerUp && sampleCnt == '0)
    else $error("conversion activity while powered down");

  ss_start_a: assert property (
    state == ACC_PDOWN && ssWrite
      |=> state == ACC_CONV && !cfgRdData[SS_BIT])
    else $error("start bit did not begin a conversion");

  ss_ignore_a: assert property (
    state == ACC_CONV && ssWrite && !lastSample
      |=> state == ACC_CONV && $stable(resultReg))
    else $error("start bit acted during a conversion");

  cont_next_a: assert property (
    state == ACC_DONE && bufInReady && !modeSingle
      |=> state == ACC_CONV ##0 resultReg == $past(convResult))
    else $error("continuous mode did not restart");

  single_stop_a: assert property (
    state == ACC_DONE && bufInReady && modeSingle
      |=> state == ACC_PDOWN [*2])
    else $error("single shot did not power down");

  whole_word_a: assert property (
    $changed(resultReg) |-> $past(state) == ACC_DONE)
    else $error("result changed outside completion");

  zero_first_a: assert property (
    !doneAny |-> resultReg.code == RESULT_RESET)
    else $error("result not zero before first conversion");

  no_overflow_a: assert property (
    bufCnt == 2'(BUF_DEPTH) && !resReady |=> !bufPush)
    else $error("buffer pushed while full");

  single_cv: cover property (
    state == ACC_PDOWN && ssWrite ##[1:1000] state == ACC_DONE
      ##1 state == ACC_PDOWN);

  cont_cv: cover property (
    state == ACC_DONE && !modeSingle ##[1:1000] state == ACC_DONE);

  full_cv: cover property (bufCnt == 2'(BUF_DEPTH) && state == ACC_DONE);

  clip_cv: cover property (lastSample && scaled > MAX_POS);

endmodule : acc_core
`default_nettype wire

// file: acc_mod_src.sv
`timescale 1ns/1ps
`default_nettype none
module acc_mod_src (
  // modulator link
  output logic modClk,
  output logic modBit
);
  logic busy;

  initial begin
    modClk = 1'b0;
    modBit = 1'b0;
    busy   = 1'b0;
  end

  // ==========================================================
  // idle line
  // clock stands low between frames; the bit keeps toggling so a
  // stray sample outside a frame never looks like a settled value
  always #20 if (!busy) modBit = ~modBit;

  // ==========================================================
  // one frame: n rising edges, the first 'ones' of them carry a one
  task automatic frame(input int ones, input int n);
    busy = 1'b1;
    for (int i = 0; i < n; i++) begin
      modBit = (i < ones);
      #32 modClk = 1'b1;
      #32 modClk = 1'b0;
    end
    busy = 1'b0;
  endtask : frame
endmodule : acc_mod_src
`default_nettype wire

// file: acc_pkg.sv
// How it works
// - gain select is the three-bit field at configuration bits 11 to 9.
// - gain codes map to six ranges, 6.144 V down to 0.256 V.
// - every result is a 16-bit twos complement word.
// - positive full scale gives 7fff, negative full scale gives 8000.
// - inputs past full scale saturate at the extreme codes, never wrap.
// - one step above zero is 0001, zero is 0000, one below is ffff.
// - temperature mode yields a 14-bit temperature result.
// - temperature sits left aligned, lowest two result bits read zero.
// - one temperature step is 0.03125 degC, 25 degC codes as 0320.
// - negative temperatures are 14-bit twos complement, -25 degC is 3ce0.
// - reset loads every configuration bit with its default value.
// - after start-up the block sits powered down, not converting.
// - while powered down the logic answers but converts nothing.
// - mode bit selects continuous (zero) or single-shot (one).
// - continuous mode stores each result and starts the next at once; the code waits in done while the two-entry buffer is full.
// - decimation is a first-order sinc filter.
// - mode bit one means power-down and single-shot operation.
// - start bit powers up, self clears, converts once, powers down.
// - start bit written during a conversion is ignored.
// - result reads zero until the first conversion completes.
package acc_pkg;

  // ==========================================================
  // configuration word layout
  localparam int SS_BIT   = 15;
  localparam int GAIN_HI  = 11;
  localparam int GAIN_LO  = 9;
  localparam int MODE_BIT = 8;
  localparam int TS_BIT   = 4;

  localparam logic [15:0] CFG_RESET    = 16'h058b;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] POS_FS_CODE  = 16'h7fff;
  localparam logic [15:0] NEG_FS_CODE  = 16'h8000;

  // ==========================================================
  // sizes and counts
  localparam int RES_BITS     = 16;
  localparam int TEMP_BITS    = 14;
  localparam int OSR_LOG2_DEF = 16;
  localparam int BUF_DEPTH    = 2;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ACC_PDOWN = 2'b00,
    ACC_CONV  = 2'b01,
    ACC_DONE  = 2'b10
  } acc_state_t;

  typedef enum logic [2:0] {
    ACC_FS_6V144 = 3'b000,
    ACC_FS_4V096 = 3'b001,
    ACC_FS_2V048 = 3'b010,
    ACC_FS_1V024 = 3'b011,
    ACC_FS_0V512 = 3'b100,
    ACC_FS_0V256 = 3'b101
  } acc_fs_t;

  typedef struct packed {
    logic [15:0] code;
    logic        isTemp;
  } acc_result_t;

endpackage : acc_pkg

// file: adc_conversion_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_tb;
  import acc_pkg::*;
  // short conversions keep the run small
  localparam int OSR = 4;
  localparam int NE  = 1 << OSR;

  logic        core_clk, rst_b, modClk, modBit, cfgWr, resReady;
  logic        powerUp, tempMode, resValid;
  logic [15:0] cfgWrData, cfgRdData;
  logic [2:0]  gainSelectField;
  acc_fs_t     fsRange;
  acc_result_t resultReg, resData;
  int          errTotal, checkCount, cyc, seed, k, n;
  logic [16:0] expQ[$];

  acc_core #(.OSR_LOG2(OSR)) dut (
    .core_clk(core_clk), .rst_b(rst_b), .modClk(modClk),
    .modBit(modBit), .cfgWr(cfgWr), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .powerUp(powerUp),
    .gainSelectField(gainSelectField), .fsRange(fsRange),
    .tempMode(tempMode), .resultReg(resultReg),
    .resValid(resValid), .resReady(resReady), .resData(resData)
  );
  acc_mod_src src (.modClk(modClk), .modBit(modBit));

  always #4 core_clk = ~core_clk;

  // ==========================================================
  // checking and reference model
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [16:0] model(input int ones, input bit t);
    int          v;
    logic [15:0] c;
    v = (ones - NE / 2) * (1 << (16 - OSR));
    if (v > 32767) v = 32767;
    c = v[15:0];
    if (t) c[1:0] = 2'b00;
    return {c, t};
  endfunction : model

  task automatic stopTest;
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stopTest

  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [15:0] d);
    @(posedge core_clk);
    cfgWr     <= 1'b1;
    cfgWrData <= d;
    @(posedge core_clk);
    cfgWr     <= 1'b0;
  endtask : wr

  // single shot, optionally with a second start in mid-conversion
  task automatic shot(input int ones, input bit t, input bit again);
    logic [15:0] d;
    logic [16:0] e;
    d = {1'b1, 3'h0, 3'h2, 1'b1, 3'h0, t, 4'h0};
    e = model(ones, t);
    expQ.push_back(e);
    wr(d);
    tick(4);
    chk(powerUp, 1'b1);
    chk(cfgRdData, {1'b0, d[14:0]});
    chk(tempMode, t);
    fork
      src.frame(ones, NE);
      if (again) begin
        tick(40);
        wr(d);
      end
    join
    k = 0;
    while (powerUp !== 1'b0 && k < 40) begin
      tick(1);
      k++;
    end
    chk(powerUp, 1'b0);
    chk(resultReg, e);
    tick(8);
    chk(powerUp, 1'b0);
    chk(17'(expQ.size()), 17'h0);
  endtask : shot

  // ==========================================================
  // reader: takes a word at each accepted pop
  always @(posedge core_clk) begin
    if (rst_b && resValid === 1'b1 && resReady === 1'b1) begin
      if (expQ.size() == 0) begin
        chk(resData, 17'h1ffff);
      end else begin
        chk(resData, expQ.pop_front());
      end
    end
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errTotal++;
      stopTest;
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    core_clk   = 1'b0;
    rst_b      = 1'b0;
    cfgWr      = 1'b0;
    cfgWrData  = 16'h0000;
    resReady   = 1'b1;
    seed       = 6774;
    errTotal   = 0;
    checkCount = 0;
    cyc        = 0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    tick(1);
    chk(cfgRdData, 16'h058b);
    chk(powerUp, 1'b0);
    chk(resultReg, 17'h0);
    // link traffic while powered down must not convert
    src.frame(NE, NE);
    tick(8);
    chk(resValid, 1'b0);
    for (int g = 0; g < 8; g++) begin
      wr({4'h0, g[2:0], 9'h183});
      tick(1);
      chk(cfgRdData, {4'h0, g[2:0], 9'h183});
      chk(gainSelectField, g[2:0]);
      chk(fsRange, (g > 5) ? 3'h5 : g[2:0]);
    end
    shot(NE, 1'b0, 1'b1);
    shot(0, 1'b0, 1'b0);
    shot(NE / 2, 1'b0, 1'b0);
    shot(NE / 2 + 1, 1'b1, 1'b0);
    shot(NE / 2 - 1, 1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      n = $unsigned($random(seed)) % (NE + 1);
      shot(n, i[0], 1'b0);
    end
    // continuous run against a stalled reader: third word waits
    resReady <= 1'b0;
    wr(16'h0480);
    tick(4);
    for (int i = 0; i < 3; i++) begin
      n = $unsigned($random(seed)) % (NE + 1);
      expQ.push_back(model(n, 1'b0));
      src.frame(n, NE);
      tick(10);
    end
    chk(powerUp, 1'b1);
    chk(resValid, 1'b1);
    chk(resData, expQ[0]);
    wr(16'h0580);
    k = 0;
    while (expQ.size() > 0 && k < 200) begin
      @(posedge core_clk);
      resReady <= ($random(seed) % 2) != 0;
      k++;
    end
    tick(8);
    chk(17'(expQ.size()), 17'h0);
    chk(powerUp, 1'b0);
    stopTest;
  end
endmodule : adc_conversion_control_tb
`default_nettype wire
